// ===== rtl/cskb_defs.vh
// constants for the compare, skip and branch execution unit
`ifndef CSKB_DEFS_VH
`define CSKB_DEFS_VH
// operation select codes
`define CSKB_OP_NONE 3'h0
`define CSKB_OP_CMP_SKIP_EQ 3'h1
`define CSKB_OP_CMP_IMM 3'h2
`define CSKB_OP_CMP_REGS 3'h3
`define CSKB_OP_SKIP_REG_CLR 3'h4
`define CSKB_OP_SKIP_IO_CLR 3'h5
`define CSKB_OP_SKIP_IO_SET 3'h6
`define CSKB_OP_BRANCH 3'h7
// status flag bit positions
`define CSKB_FLAG_C 3'h0
`define CSKB_FLAG_Z 3'h1
`define CSKB_FLAG_N 3'h2
`define CSKB_FLAG_V 3'h3
`define CSKB_FLAG_S 3'h4
`define CSKB_FLAG_H 3'h5
// reset values
`define CSKB_PC_RST 16'h0000
`define CSKB_FLAGS_RST 8'h00
`define CSKB_WAIT_RST 2'h0
`define CSKB_CYC_RST 2'h0
`define CSKB_DONE_RST 1'h0
// program counter steps
`define CSKB_STEP_ONE 16'h0001
`define CSKB_STEP_SKIP1 16'h0002
`define CSKB_STEP_SKIP2 16'h0003
// cycle counts
`define CSKB_CYC_ONE 2'h1
`define CSKB_CYC_TWO 2'h2
`define CSKB_CYC_THREE 2'h3
`endif

// ===== rtl/cskb_exec.v
// execution of compare, skip and branch instructions: pc, flags, cycle timing
// Notes on behaviour
// - equal registers skip next instruction, flags kept
// - compare immediate subtracts, sets Z N V S C H
// - register bit zero skips next instruction
// - io bit zero skips next instruction
// - io bit one skips next instruction
// - flag set branches to pc plus offset plus one
// - flag clear branches likewise, flags kept
// - branch costs one cycle, two when taken
`timescale 1ns/1ps
`include "cskb_defs.vh"
module cskb_exec #(
  parameter PC_W = 16
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // instruction issue
  input wire ISSUE,
  input wire [2:0] OP,
  input wire [7:0] RD_VAL,
  input wire [7:0] RR_VAL,
  input wire [7:0] IMM,
  input wire [2:0] BIT_SEL,
  input wire [7:0] IO_VAL,
  input wire BRANCH_ON_SET,
  input wire signed [6:0] OFFSET,
  input wire NEXT_TWO_WORDS,
  // results
  output wire BUSY,
  output wire [PC_W-1:0] PC,
  output wire [7:0] FLAGS,
  output wire [1:0] LAST_CYCLES,
  output wire DONE
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [1:0] wait_ff;
  reg [1:0] nxt_wait;
  reg [PC_W-1:0] pc_ff;
  reg [PC_W-1:0] nxt_pc;
  reg [7:0] flags_ff;
  reg [7:0] nxt_flags;
  reg [1:0] cyc_ff;
  reg [1:0] nxt_cyc;
  reg done_ff;
  reg nxt_done;

  // compare datapath, shared by both compare forms
  wire [7:0] cmp_b = (OP == `CSKB_OP_CMP_IMM) ? IMM : RR_VAL;
  wire [8:0] diff = {1'b0, RD_VAL} - {1'b0, cmp_b};
  wire [7:0] res = diff[7:0];
  wire f_c = diff[8];
  wire f_z = (res == 8'h00);
  wire f_n = res[7];
  wire f_v = (RD_VAL[7] & ~cmp_b[7] & ~res[7]) | (~RD_VAL[7] & cmp_b[7] & res[7]);
  wire f_h = (~RD_VAL[3] & cmp_b[3]) | (cmp_b[3] & res[3]) | (res[3] & ~RD_VAL[3]);

  // skip step depends on size of the skipped instruction
  wire [PC_W-1:0] skip_step = NEXT_TWO_WORDS ? `CSKB_STEP_SKIP2 : `CSKB_STEP_SKIP1;
  wire [1:0] skip_cyc = NEXT_TWO_WORDS ? `CSKB_CYC_THREE : `CSKB_CYC_TWO;
  wire rr_bit;
  wire io_bit;
  wire flag_bit;

  // register operand bit for the register bit skip
  cskb_bit_pick #(
    .W(8),
    .SW(3)
  ) u_cskb_bit_pick_rr (
    .vec(RR_VAL),
    .sel(BIT_SEL),
    .pick(rr_bit)
  );

  // io register bit for both io bit skips
  cskb_bit_pick #(
    .W(8),
    .SW(3)
  ) u_cskb_bit_pick_io (
    .vec(IO_VAL),
    .sel(BIT_SEL),
    .pick(io_bit)
  );

  // status bit read from the registered flags, so a compare in the
  // previous cycle is already visible to the branch that follows
  cskb_bit_pick #(
    .W(8),
    .SW(3)
  ) u_cskb_bit_pick_flag (
    .vec(flags_ff),
    .sel(BIT_SEL),
    .pick(flag_bit)
  );

  // branch_equal is the set-form branch on the zero flag
  wire br_take = BRANCH_ON_SET ? flag_bit : ~flag_bit;
  wire [PC_W-1:0] br_off = {{(PC_W-7){OFFSET[6]}}, OFFSET};

  reg skip_take;

  // next state: decide on issue, then hold busy for extra cycles
  always @* begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_pc = pc_ff;
    nxt_flags = flags_ff;
    nxt_cyc = cyc_ff;
    nxt_done = 1'b0;
    skip_take = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ISSUE) begin
          nxt_pc = pc_ff + `CSKB_STEP_ONE;
          nxt_cyc = `CSKB_CYC_ONE;
          case (OP)
            `CSKB_OP_CMP_SKIP_EQ: skip_take = (RD_VAL == RR_VAL);
            `CSKB_OP_SKIP_REG_CLR: skip_take = ~rr_bit;
            `CSKB_OP_SKIP_IO_CLR: skip_take = ~io_bit;
            `CSKB_OP_SKIP_IO_SET: skip_take = io_bit;
            `CSKB_OP_CMP_IMM, `CSKB_OP_CMP_REGS: begin
              // result is discarded, only flags change
              nxt_flags[`CSKB_FLAG_C] = f_c;
              nxt_flags[`CSKB_FLAG_Z] = f_z;
              nxt_flags[`CSKB_FLAG_N] = f_n;
              nxt_flags[`CSKB_FLAG_V] = f_v;
              nxt_flags[`CSKB_FLAG_S] = f_n ^ f_v;
              nxt_flags[`CSKB_FLAG_H] = f_h;
            end
            `CSKB_OP_BRANCH: begin
              if (br_take) begin
                nxt_pc = pc_ff + br_off + `CSKB_STEP_ONE;
                nxt_cyc = `CSKB_CYC_TWO;
              end
            end
            default: nxt_cyc = cyc_ff;
          endcase
          if (skip_take) begin
            nxt_pc = pc_ff + skip_step;
            nxt_cyc = skip_cyc;
          end
          if (OP == `CSKB_OP_NONE) begin
            nxt_pc = pc_ff;
          end else if (nxt_cyc == `CSKB_CYC_ONE) begin
            nxt_done = 1'b1;
          end else begin
            nxt_wait = nxt_cyc - `CSKB_CYC_ONE;
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // extra cycles of a taken skip or branch; issue ignored meanwhile
        nxt_wait = wait_ff - `CSKB_CYC_ONE;
        if (wait_ff == `CSKB_CYC_ONE) begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // issue sequencing registers
  always @(posedge CLK) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      wait_ff <= `CSKB_WAIT_RST;
      done_ff <= `CSKB_DONE_RST;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      done_ff <= nxt_done;
    end
  end

  // program counter, reset to the start of program space
  always @(posedge CLK) begin
    if (!RSTN) begin
      pc_ff <= `CSKB_PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // status flags, written only by the two compares
  always @(posedge CLK) begin
    if (!RSTN) begin
      flags_ff <= `CSKB_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // cycle count of the last op, held until the next issued op other than none
  always @(posedge CLK) begin
    if (!RSTN) begin
      cyc_ff <= `CSKB_CYC_RST;
    end else begin
      cyc_ff <= nxt_cyc;
    end
  end

  assign BUSY = state_ff[1]; // busy comes straight from the state register
  assign PC = pc_ff;
  assign FLAGS = flags_ff;
  assign LAST_CYCLES = cyc_ff;
  assign DONE = done_ff;
endmodule

// one bit chosen out of a vector
module cskb_bit_pick #(
  parameter W = 8,
  parameter SW = 3
) (
  // vector and bit number
  input wire [W-1:0] vec,
  input wire [SW-1:0] sel,
  // chosen bit
  output wire pick
);
  // combinational, so the skip decision stays in the issue cycle
  assign pick = vec[sel];
endmodule

// ===== dv/cskb_exec_assertions.sv
// port checker for the compare, skip and branch unit
`timescale 1ns/1ps
module cskb_exec_assertions (
  input wire CLK, RSTN, ISSUE, BRANCH_ON_SET, NEXT_TWO_WORDS, BUSY, DONE,
  input wire [2:0] OP, BIT_SEL,
  input wire [7:0] RD_VAL, RR_VAL, IMM, IO_VAL, FLAGS,
  input wire signed [6:0] OFFSET,
  input wire [15:0] PC,
  input wire [1:0] LAST_CYCLES
);
  wire t = ISSUE && !BUSY;
  wire hit = FLAGS[BIT_SEL] == BRANCH_ON_SET;
  reg [15:0] skip_ff;
  reg [15:0] jump_ff;
  // targets from the values seen at the take edge
  always @(posedge CLK) begin
    skip_ff <= PC + 16'h2 + NEXT_TWO_WORDS;
    jump_ff <= PC + {{9{OFFSET[6]}}, OFFSET} + 16'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  eq_skip_a: assert property (t && OP == 3'h1 && RD_VAL == RR_VAL |=>
    PC == skip_ff && $stable(FLAGS)) else $error("equal skip");
  cmp_flags_a: assert property (t && OP == 3'h2 |=> DONE &&
    FLAGS[1:0] == {$past(RD_VAL) == $past(IMM), $past(RD_VAL) < $past(IMM)})
    else $error("compare flags");
  rbit_skip_a: assert property (t && OP == 3'h4 && !RR_VAL[BIT_SEL] |=>
    PC == skip_ff) else $error("reg bit skip");
  ioclr_skip_a: assert property (t && OP == 3'h5 && !IO_VAL[BIT_SEL] |=>
    PC == skip_ff) else $error("io clear skip");
  ioset_skip_a: assert property (t && OP == 3'h6 && IO_VAL[BIT_SEL] |=>
    PC == skip_ff) else $error("io set skip");
  skip_flags_a: assert property (t && OP >= 3'h4 && OP <= 3'h6 |=>
    $stable(FLAGS)) else $error("skip flags");
  br_taken_a: assert property (t && OP == 3'h7 && hit |=> PC == jump_ff &&
    LAST_CYCLES == 2'h2 && BUSY ##1 DONE && !BUSY) else $error("branch taken");
  br_keep_a: assert property (t && OP == 3'h7 |=> $stable(FLAGS))
    else $error("branch flags");
  br_fall_a: assert property (t && OP == 3'h7 && !hit |=> LAST_CYCLES == 2'h1
    && DONE && !BUSY) else $error("branch not taken");
  skip_cyc_a: assert property (t && OP == 3'h4 && !RR_VAL[BIT_SEL] &&
    NEXT_TWO_WORDS |=> LAST_CYCLES == 2'h3 && BUSY ##1 BUSY ##1 DONE && !BUSY)
    else $error("skip cycles");
endmodule
bind cskb_exec cskb_exec_assertions u_chk (.CLK, .RSTN, .ISSUE, .BRANCH_ON_SET,
  .NEXT_TWO_WORDS, .BUSY, .DONE, .OP, .BIT_SEL, .RD_VAL, .RR_VAL, .IMM, .IO_VAL,
  .FLAGS, .OFFSET, .PC, .LAST_CYCLES);

// ===== dv/test_cskb_exec.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
module test_cskb_exec;
  reg clk = 0, rstn = 0, iss = 0, f = 0, n = 0;
  reg [2:0] op = 0, s = 0, o;
  reg [7:0] a = 0, b = 0, rr = 0, im = 0;
  reg [6:0] k = 0;
  reg [15:0] ep = 0;
  reg sk;
  wire busy, done;
  wire [15:0] pc;
  wire [7:0] fl;
  wire [1:0] cy;
  integer error_cnt = 0, samples_checked = 0, i;
  // io byte is the source as given; register and immediate get it or its inverse
  cskb_exec u_cskb_exec (.CLK(clk), .RSTN(rstn), .ISSUE(iss), .OP(op), .RD_VAL(a),
    .RR_VAL(rr), .IMM(im), .BIT_SEL(s), .IO_VAL(b), .BRANCH_ON_SET(f), .OFFSET(k),
    .NEXT_TWO_WORDS(n), .BUSY(busy), .PC(pc), .FLAGS(fl), .LAST_CYCLES(cy), .DONE(done));
  always #50 clk = ~clk;
  task chk(input [63:0] nm, input [15:0] e, g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // issue one op, count the edges up to its done pulse, then idle one edge
  task go(input [2:0] x, input [7:0] y, z, input [2:0] w, input v, input [6:0] m,
    input u, input [15:0] st, input [1:0] c);
    reg [15:0] nc;
    begin
      op = x;
      a = y;
      b = z;
      rr = (x == 3'h2) ? ~z : z;
      im = (x == 3'h2) ? z : ~z;
      s = w;
      f = v;
      k = m;
      n = u;
      iss = 1;
      @(posedge clk) #1 iss = 0;
      ep = ep + st;
      chk("pc", ep, pc);
      chk("cycles", c, cy);
      nc = 16'h1;
      while (!done && nc < 16'h4) begin
        @(posedge clk) #1 nc = nc + 16'h1;
      end
      chk("done_at", c, nc);
      chk("busy", 16'h0, busy);
      @(posedge clk) #1;
    end
  endtask
  task t_cmp_branch;
    begin
      go(3'h2, 8'h10, 8'h10, 3'h0, 0, 7'h0, 0, 16'h1, 2'h1);
      chk("flags", 8'h02, fl);
      go(3'h7, 8'h0, 8'h0, 3'h1, 1, 7'h7e, 0, 16'hffff, 2'h2);
      go(3'h7, 8'h0, 8'h0, 3'h1, 0, 7'h7e, 0, 16'h1, 2'h1);
      go(3'h2, 8'h00, 8'h01, 3'h0, 0, 7'h0, 0, 16'h1, 2'h1);
      chk("flags", 8'h35, fl);
      go(3'h7, 8'h0, 8'h0, 3'h0, 1, 7'h05, 0, 16'h6, 2'h2);
      go(3'h7, 8'h0, 8'h0, 3'h5, 0, 7'h05, 0, 16'h1, 2'h1);
      go(3'h3, 8'h80, 8'h01, 3'h0, 0, 7'h0, 0, 16'h1, 2'h1);
      chk("flags", 8'h38, fl);
      go(3'h7, 8'h0, 8'h0, 3'h3, 1, 7'h02, 0, 16'h3, 2'h2);
    end
  endtask
  // issue kept high through a busy branch, then an issue of no op
  task t_hold;
    begin
      op = 3'h7;
      s = 3'h3;
      f = 1;
      k = 7'h02;
      iss = 1;
      @(posedge clk) #1;
      op = 3'h2;
      a = 8'h00;
      im = 8'h01;
      ep = ep + 16'h3;
      chk("pc", ep, pc);
      chk("busy", 16'h1, busy);
      @(posedge clk) #1;
      iss = 0;
      chk("done", 16'h1, done);
      chk("pc", ep, pc);
      chk("flags", 8'h38, fl);
      @(posedge clk) #1;
      op = 3'h0;
      iss = 1;
      @(posedge clk) #1;
      iss = 0;
      chk("pc", ep, pc);
      chk("cycles", 16'h2, cy);
      chk("done", 16'h0, done);
      @(posedge clk) #1;
    end
  endtask
  // ops 1 4 5 6 with bit three clear then set, one and two word targets
  task t_skips;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        o = (i % 4 == 0) ? 3'h1 : 3'h3 + i % 4;
        sk = (o == 3'h6) == (i / 4 % 2);
        go(o, 8'hf7, (i / 4 % 2) ? 8'h08 : 8'hf7, 3'h3, 0, 7'h0, i / 8,
          sk ? 16'h2 + i / 8 : 16'h1, sk ? 2'h2 + i / 8 : 2'h1);
      end
      chk("flags", 8'h38, fl);
    end
  endtask
  // reset in the middle of a three cycle skip, then a first op right after
  task t_reset;
    begin
      op = 3'h4;
      rr = 8'h00;
      s = 3'h0;
      n = 1;
      iss = 1;
      @(posedge clk) #1;
      iss = 0;
      rstn = 0;
      chk("busy", 16'h1, busy);
      repeat (2) @(posedge clk);
      #1 rstn = 1;
      ep = 16'h0;
      chk("pc", ep, pc);
      chk("flags", 16'h0, fl);
      chk("cycles", 16'h0, cy);
      chk("busy", 16'h0, busy);
      chk("done", 16'h0, done);
      go(3'h1, 8'h5a, 8'h5a, 3'h0, 0, 7'h0, 0, 16'h2, 2'h2);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    chk("pc", 16'h0, pc);
    t_cmp_branch;
    t_hold;
    t_skips;
    t_reset;
    finish_test;
  end
  initial begin
    #100000 error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule
